// ===== spi_host_port.sv
// Device-side serial host port: interface select, SPI framing, register and FIFO access.
// Assumes the register file answers reads combinationally and the FIFO presents a word
// whenever it signals valid; all host pins are asynchronous to clk.
//
// Notes on behaviour
// - Select pin high: two-wire mode, SPI held reset.
// - Select pin low: two-wire off, SPI active.
// - Sample input on rising, change output falling, except later burst words appear on rising.
// - Single access is three bytes, 24 clocks.
// - Order: address, command, then data byte.
// - Write commits on 24th rising edge.
// - Write ignores bits after the 24th edge.
// - Early select rise aborts, no write.
// - Read fetched at 16th edge, MSB next fall.
// - Normal read: zeros after 24 clocks.
// - Burst: FIFO words every 24 clocks onward.
// - FIFO word: 4-bit tag plus 20-bit value.
`timescale 1ns/1ns
`default_nettype none
module spi_host_port
  import spi_port_pkg::*;
#(
  parameter logic [7:0] CMD_WRITE = CMD_WRITE_DEF,
  parameter logic [7:0] CMD_READ  = CMD_READ_DEF,
  parameter logic [7:0] CMD_BURST = CMD_BURST_DEF
) (
  // System
  input  wire logic       clk,
  input  wire logic       reset,
  // Host pins
  input  wire logic       interface_select_pin,
  input  wire logic       serial_clock_pin,
  input  wire logic       serial_input_shared_pin,
  output logic            serial_output_pin,
  output logic            serial_output_oe,
  // Mode
  output logic            two_wire_enable,
  // Register file
  output var reg_write_s  reg_write,
  output logic            reg_write_strobe,
  output logic [7:0]      reg_read_addr,
  output logic            reg_read_strobe,
  input  wire logic [7:0] reg_read_data,
  // FIFO read side
  input  wire fifo_word_s fifo_word,
  input  wire logic       fifo_valid,
  output logic            fifo_pop
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sel_sync_reg;
  logic [1:0] sck_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic       sck_prev_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_sync_reg <= 2'h3;
      sck_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      sck_prev_reg <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], interface_select_pin};
      sck_sync_reg <= {sck_sync_reg[0], serial_clock_pin};
      sdi_sync_reg <= {sdi_sync_reg[0], serial_input_shared_pin};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  logic sel_high;
  logic sck_rise;
  logic sck_fall;
  logic sdi_bit;
  assign sel_high = sel_sync_reg[1];
  assign sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
  assign sck_fall = ~sck_sync_reg[1] & sck_prev_reg;
  assign sdi_bit  = sdi_sync_reg[1];

  assign two_wire_enable = sel_high;

  // ----------------------------------------------------------------
  // Frame counter and state
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] bit_cnt_reg;
  frame_state_e     state_reg;
  op_e              op_reg;
  logic [7:0]       shift_in_reg;
  logic [7:0]       addr_reg;
  logic [7:0]       in_next;
  logic [CNT_W-1:0] cnt_next;

  assign in_next  = {shift_in_reg[6:0], sdi_bit};
  assign cnt_next = CNT_W'(bit_cnt_reg + CNT_ONE);

  logic [WORD_W-1:0] shift_out_reg;

  // A burst word boundary falls on every 24th edge after the command byte.
  logic word_end;
  assign word_end = sck_rise && (state_reg == ST_DATA) && (cnt_next == CNT_FRAME_END);

  always_ff @(posedge clk) begin
    if (reset || sel_high) begin
      bit_cnt_reg  <= CNT_ZERO;
      state_reg    <= ST_ADDR;
      op_reg       <= OP_NONE;
      shift_in_reg <= 8'h00;
      addr_reg     <= 8'h00;
    end else if (sck_rise) begin
      shift_in_reg <= in_next;
      case (state_reg)
        ST_ADDR: begin
          bit_cnt_reg <= cnt_next;
          if (cnt_next == CNT_ADDR_END) begin
            addr_reg  <= in_next;
            state_reg <= ST_CMD;
          end
        end
        ST_CMD: begin
          bit_cnt_reg <= cnt_next;
          if (cnt_next == CNT_CMD_END) begin
            state_reg <= ST_DATA;
            if (in_next == CMD_WRITE) begin
              op_reg <= OP_WRITE;
            end else if (in_next == CMD_BURST) begin
              // Burst words are a full 24 edges long, so the count restarts here.
              op_reg      <= OP_BURST;
              bit_cnt_reg <= CNT_ZERO;
            end else if (in_next == CMD_READ) begin
              op_reg <= OP_READ;
            end else begin
              op_reg <= OP_NONE;
            end
          end
        end
        ST_DATA: begin
          if (cnt_next == CNT_FRAME_END) begin
            if (op_reg == OP_BURST) begin
              bit_cnt_reg <= CNT_ZERO;
            end else begin
              bit_cnt_reg <= cnt_next;
              state_reg   <= ST_IDLE;
            end
          end else begin
            bit_cnt_reg <= cnt_next;
          end
        end
        ST_IDLE: begin
          bit_cnt_reg <= bit_cnt_reg;
        end
        default: begin
          state_reg <= ST_ADDR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register write and read fetch
  // ----------------------------------------------------------------
  logic cmd_done;
  assign cmd_done = sck_rise && (state_reg == ST_CMD) && (cnt_next == CNT_CMD_END);

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_write        <= '0;
      reg_write_strobe <= 1'b0;
    end else begin
      // A frame cut short never reaches ST_DATA's last edge, so nothing commits.
      reg_write_strobe <= 1'b0;
      if (!sel_high && word_end && op_reg == OP_WRITE) begin
        reg_write.addr   <= addr_reg;
        reg_write.data   <= in_next;
        reg_write_strobe <= 1'b1;
      end
    end
  end

  assign reg_read_addr   = addr_reg;
  assign reg_read_strobe = !sel_high && cmd_done && (in_next == CMD_READ);
  assign fifo_pop        = !sel_high && fifo_valid &&
                           ((cmd_done && in_next == CMD_BURST) ||
                            (word_end && op_reg == OP_BURST));

  // ----------------------------------------------------------------
  // Output shifter, loaded on rising edges and shifted on falling edges
  // ----------------------------------------------------------------
  logic load_pending_reg;
  logic out_active_reg;

  always_ff @(posedge clk) begin
    if (reset || sel_high) begin
      shift_out_reg    <= '0;
      load_pending_reg <= 1'b0;
      out_active_reg   <= 1'b0;
    end else if (reg_read_strobe) begin
      shift_out_reg    <= {reg_read_data, 16'h0000};
      load_pending_reg <= 1'b1;
    end else if (fifo_pop) begin
      shift_out_reg    <= fifo_valid ? fifo_word : '0;
      load_pending_reg <= 1'b1;
    end else if (sck_fall) begin
      if (load_pending_reg) begin
        load_pending_reg <= 1'b0;
        out_active_reg   <= 1'b1;
      end else begin
        shift_out_reg <= {shift_out_reg[WORD_MSB-1:0], 1'b0};
      end
    end else if (word_end && op_reg == OP_BURST && !fifo_valid) begin
      shift_out_reg    <= '0;
      load_pending_reg <= 1'b1;
    end
  end

  assign serial_output_pin = out_active_reg & shift_out_reg[WORD_MSB];
  assign serial_output_oe  = ~sel_high;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_select_resets: assert property (@(posedge clk) disable iff (reset)
    sel_high |=> (bit_cnt_reg == CNT_ZERO && state_reg == ST_ADDR))
    else $error("Frame logic not reset while select high.");
  a_twowire_follows: assert property (@(posedge clk) disable iff (reset)
    sel_high |-> (two_wire_enable && !serial_output_oe) ##1 !serial_output_pin)
    else $error("Two-wire mode not clean while select high.");
  a_write_on_last: assert property (@(posedge clk) disable iff (reset)
    reg_write_strobe |-> $past(state_reg) == ST_DATA && $past(op_reg) == OP_WRITE)
    else $error("Write outside the last data edge.");
  a_no_late_write: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_IDLE |=> !reg_write_strobe)
    else $error("Write after the frame end.");
  a_abort_no_write: assert property (@(posedge clk) disable iff (reset)
    sel_high |=> !reg_write_strobe)
    else $error("Write after select rose.");
  a_read_at_16: assert property (@(posedge clk) disable iff (reset)
    reg_read_strobe |-> bit_cnt_reg == CNT_CMD_END - CNT_ONE)
    else $error("Register fetch not on the 16th edge.");
  a_zeros_after: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_IDLE && op_reg == OP_READ && sck_fall) |=> !serial_output_pin)
    else $error("Nonzero output beyond frame end.");
  a_decode_once: assert property (@(posedge clk) disable iff (reset)
    (cmd_done && !sel_high) |=> state_reg == ST_DATA)
    else $error("Command byte not decoded.");
  a_burst_wraps: assert property (@(posedge clk) disable iff (reset)
    (word_end && op_reg == OP_BURST && !sel_high) |=> bit_cnt_reg == CNT_ZERO)
    else $error("Burst counter did not wrap.");

endmodule
`default_nettype wire

// ===== spi_port_pkg.sv
// Shared constants, command codes, states and carrier structs for the serial host port.
// Assumes a single system clock; host pins are asynchronous and synchronised in the port.
`default_nettype none
package spi_port_pkg;

  localparam int unsigned FRAME_BITS    = 24;
  localparam int unsigned CNT_W         = 5;
  localparam logic [CNT_W-1:0] CNT_ADDR_END  = 5'h08;
  localparam logic [CNT_W-1:0] CNT_CMD_END   = 5'h10;
  localparam logic [CNT_W-1:0] CNT_FRAME_END = 5'h18;
  localparam logic [CNT_W-1:0] CNT_ZERO      = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE       = 5'h01;

  // Command codes are not fixed by the port itself; defaults are arbitrary.
  localparam logic [7:0] CMD_WRITE_DEF = 8'h00;
  localparam logic [7:0] CMD_READ_DEF  = 8'h80;
  localparam logic [7:0] CMD_BURST_DEF = 8'h81;

  localparam int unsigned TAG_W  = 4;
  localparam int unsigned DATA_W = 20;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned WORD_MSB = 23;

  typedef enum logic [1:0] {
    ST_ADDR  = 2'b00,
    ST_CMD   = 2'b01,
    ST_DATA  = 2'b11,
    ST_IDLE  = 2'b10
  } frame_state_e;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_BURST = 2'b11
  } op_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_s;

  typedef struct packed {
    logic [TAG_W-1:0]  tag;
    logic [DATA_W-1:0] value;
  } fifo_word_s;

endpackage
`default_nettype wire

// ===== spi_host_model.sv
// Host-side SPI controller model that drives the serial port pins.
// Assumes the bench calls frame() from one process at a time.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  // System
  input  wire logic clk,
  // Serial pins
  output logic      select_pin,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    select_pin = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // The port synchronises its pins, so each half period is eight system clocks.
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                       input int n, output logic [63:0] rx);
    logic [63:0] tx;
    tx = {a, c, d, {5{~d}}};
    rx = '0;
    @(posedge clk);
    #1;
    select_pin = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = tx[63];
      tx = tx << 1;
      half();
      rx = {rx[62:0], sdo};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    select_pin = 1'b1;
    sdi = ~sdi;
    half();
  endtask
endmodule
`default_nettype wire

// ===== bioz_afe_spi_host_port_tb.sv
// Self-checking bench: a table of frames, then read overrun, abort, overrun, burst and reset cases.
// Assumes the host model owns the serial pins; register file and FIFO are modelled here.
`timescale 1ns/1ns
`default_nettype none
module bioz_afe_spi_host_port_tb;
  import spi_port_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] c;
    logic [7:0] d;
    logic       w;
    logic [7:0] q;
  } row_s;
  logic        clk, reset, sel, sclk, sdi, sdo, sdo_oe, two_wire, wr_stb, rd_stb, pop;
  reg_write_s  wr, wr_last;
  logic [7:0]  rd_addr;
  fifo_word_s  word;
  logic [3:0]  pops;
  logic [63:0] rx;
  int          bad_count, cmp_count, wr_cnt, rd_cnt;
  row_s        rows [5];
  spi_host_port u_spi_host_port (
    .clk(clk), .reset(reset), .interface_select_pin(sel), .serial_clock_pin(sclk),
    .serial_input_shared_pin(sdi), .serial_output_pin(sdo), .serial_output_oe(sdo_oe),
    .two_wire_enable(two_wire), .reg_write(wr), .reg_write_strobe(wr_stb),
    .reg_read_addr(rd_addr), .reg_read_strobe(rd_stb), .reg_read_data(rd_addr ^ 8'h5a),
    .fifo_word(word), .fifo_valid(1'b1), .fifo_pop(pop));
  spi_host_model u_spi_host_model (
    .clk(clk), .select_pin(sel), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  assign word = '{tag: 4'ha + pops, value: 20'h12345 + 20'(pops)};
  always @(posedge clk) begin
    if (pop) pops <= pops + 4'h1;
    if (rd_stb) rd_cnt <= rd_cnt + 1;
    if (wr_stb) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= wr;
    end
  end
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // The frames take about 44 us, so this limit only trips on a hang.
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n0, n1;
    reset = 1'b1;
    pops = 4'h0;
    wr_cnt = 0;
    rd_cnt = 0;
    rows = '{'{8'h12, CMD_WRITE_DEF, 8'ha5, 1'b1, 8'h00},
             '{8'hff, CMD_WRITE_DEF, 8'h3c, 1'b1, 8'h00},
             '{8'h12, CMD_READ_DEF, 8'h77, 1'b0, 8'h48},
             '{8'h00, CMD_READ_DEF, 8'h00, 1'b0, 8'h5a},
             '{8'h12, 8'h42, 8'h99, 1'b0, 8'h00}};
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("two-wire on", 1, two_wire);
    check("oe idle", 0, sdo_oe);
    foreach (rows[i]) begin
      n0 = wr_cnt;
      n1 = rd_cnt;
      u_spi_host_model.frame(rows[i].a, rows[i].c, rows[i].d, 24, rx);
      check("write count", rows[i].w, wr_cnt - n0);
      check("read strobes", rows[i].c == CMD_READ_DEF, rd_cnt - n1);
      if (rows[i].w) check("write", {rows[i].a, rows[i].d}, wr_last);
      else check("read byte", rows[i].q, rx[7:0]);
    end
    fork
      u_spi_host_model.frame(8'h33, CMD_READ_DEF, 8'h00, 40, rx);
      begin
        repeat (40) @(posedge clk);
        #2;
        check("two-wire off", 0, two_wire);
        check("oe active", 1, sdo_oe);
      end
    join
    check("read tail", 24'h690000, rx[23:0]);
    n0 = wr_cnt;
    u_spi_host_model.frame(8'h21, CMD_WRITE_DEF, 8'hc3, 23, rx);
    check("aborted write", 0, wr_cnt - n0);
    u_spi_host_model.frame(8'h44, CMD_WRITE_DEF, 8'h81, 40, rx);
    check("overrun write count", 1, wr_cnt - n0);
    check("write after abort", 16'h4481, wr_last);
    u_spi_host_model.frame(8'h0c, CMD_BURST_DEF, 8'h00, 64, rx);
    check("burst words", {4'ha, 20'h12345, 4'hb, 20'h12346}, rx[47:0]);
    check("burst tag", 4'hb, rx[23:20]);
    // A reset in mid-frame must drop the frame and leave the port usable.
    n0 = wr_cnt;
    fork
      u_spi_host_model.frame(8'h5e, CMD_WRITE_DEF, 8'h11, 24, rx);
      begin
        repeat (200) @(posedge clk);
        #1;
        reset = 1'b1;
        @(posedge clk);
        #1;
        check("reset two-wire", 1, two_wire);
        check("reset oe", 0, sdo_oe);
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
      end
    join
    check("reset abort", 0, wr_cnt - n0);
    u_spi_host_model.frame(8'h5e, CMD_WRITE_DEF, 8'h11, 24, rx);
    check("write after reset", 16'h5e11, wr_last);
    print_verdict();
  end
endmodule
`default_nettype wire
